// *** llas_blink_div.v ***
// blink divider: one-cycle enable pulse every period cycles
`timescale 1ns/1ps
`include "llas_map.vh"
module llas_blink_div #(
	parameter PERIOD = `LLAS_BLINK_CYC
) (
	// clock and reset
	input wire clk,
	input wire rstn,
	// enable pulse out
	output reg tick
);
	reg [23:0] cnt_q;
	always @(posedge clk) begin
		if (!rstn) begin
			cnt_q <= 24'h000000;
			tick <= 1'b0;
		end else if (cnt_q >= PERIOD[23:0] - 24'h000001) begin
			cnt_q <= 24'h000000;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 24'h000001;
			tick <= 1'b0;
		end
	end
endmodule

// *** llas_board.sv ***
// board model: lamp pin with strap resistor
`timescale 1ns/1ps
module llas_board (
	// from the device
	input wire statusLampOut,
	input wire statusLampOe,
	// strap resistor
	input wire strapLevel,
	// pin level
	output wire pinLevel
);
	// strap resistor outweighs the weak pull-up when undriven
	assign pinLevel = statusLampOe ? statusLampOut : strapLevel;
endmodule

// *** llas_lamp_strap.v ***
// status lamp pin with auto-negotiation strap, axi4-lite register slave
// Summary of operation
// - the lamp pin level sampled during reset is loaded into control bit 12 as autoneg enable in the first cycle after reset is released.
// - with fiber mode select at 0 the sampled strap level becomes the autoneg enable bit.
// - with fiber mode select at 1 autoneg enable is forced off whatever the strap level.
// - the lamp behaviour is chosen by the two-bit mode field in bits 15 to 14 of the lamp register.
// - mode 00 lamp high without link, low with link, toggling on activity; mode 01 ignores activity.
`timescale 1ns/1ps
`include "llas_map.vh"
module llas_lamp_strap #(
	parameter BLINK_CYC = `LLAS_BLINK_CYC
) (
	// clock and reset
	input wire clk,
	input wire rstn,
	// lamp pin
	input wire statusLampIn,
	output reg statusLampOut,
	output reg statusLampOe,
	output reg statusLampPullup,
	// phy status and strap inputs
	input wire linkUp,
	input wire activity,
	input wire fiberModeSelect,
	// control output
	output reg autonegEnable,
	// axi4-lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
	reg [1:0] pinSync_q;
	reg [1:0] linkSync_q;
	reg [1:0] actSync_q;
	reg [1:0] fiberSync_q;
	reg [15:0] ctrl_q;
	reg [1:0] lampMode_q;
	reg inReset_q;
	reg blink_q;
	reg [7:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg awHave_q;
	reg wHave_q;
	wire blinkTick;
	wire pinLevel = pinSync_q[1];
	wire linkLevel = linkSync_q[1];
	wire actLevel = actSync_q[1];
	wire fiberLevel = fiberSync_q[1];
	wire wrGo = awHave_q && wHave_q && !s_axi_bvalid;
	wire strapAnen = fiberLevel ? 1'b0 : pinLevel;
	reg lampNext;

	llas_blink_div #(
		.PERIOD(BLINK_CYC)
	) u_div (
		.clk(clk),
		.rstn(rstn),
		.tick(blinkTick)
	);

	// pin and status synchronisers, first stage read only by second
	always @(posedge clk) begin
		pinSync_q <= {pinSync_q[0], statusLampIn};
		linkSync_q <= {linkSync_q[0], linkUp};
		actSync_q <= {actSync_q[0], activity};
		fiberSync_q <= {fiberSync_q[0], fiberModeSelect};
	end

	always @(posedge clk) begin
		if (!rstn) begin
			inReset_q <= 1'b1;
			statusLampOe <= 1'b0;
			statusLampPullup <= 1'b1;
		end else begin
			inReset_q <= 1'b0;
			statusLampOe <= 1'b1;
			statusLampPullup <= 1'b0;
		end
	end

	always @* begin
		lampNext = 1'b1;
		case (lampMode_q)
			`LLAS_MODE_LINKACT: begin
				lampNext = !linkLevel ? 1'b1 : (actLevel ? blink_q : 1'b0);
			end
			`LLAS_MODE_LINK: begin
				lampNext = !linkLevel;
			end
			default: begin
				// reserved modes keep the lamp off
				lampNext = 1'b1;
			end
		endcase
	end

	always @(posedge clk) begin
		if (!rstn) begin
			blink_q <= 1'b0;
			statusLampOut <= 1'b1;
		end else begin
			if (blinkTick) begin
				blink_q <= !blink_q;
			end
			statusLampOut <= lampNext;
		end
	end

	// control register, strap loaded in the first cycle after reset is released
	always @(posedge clk) begin
		if (!rstn) begin
			ctrl_q <= `LLAS_CTRL_RST;
			lampMode_q <= `LLAS_MODE_RST;
			autonegEnable <= 1'b0;
		end else begin
			if (inReset_q) begin
				ctrl_q[`LLAS_ANEN_BIT] <= strapAnen;
			end else if (wrGo && awaddr_q == `LLAS_CTRL_ADDR) begin
				if (wstrb_q[0]) begin
					ctrl_q[7:0] <= wdata_q[7:0];
				end
				if (wstrb_q[1]) begin
					ctrl_q[15:8] <= wdata_q[15:8];
				end
			end
			if (!inReset_q && wrGo && awaddr_q == `LLAS_LAMP_ADDR && wstrb_q[1]) begin
				lampMode_q <= wdata_q[`LLAS_MODE_HI:`LLAS_MODE_LO];
			end
			autonegEnable <= inReset_q ? strapAnen : ctrl_q[`LLAS_ANEN_BIT];
		end
	end

	// write channel: address and data taken in either order
	always @(posedge clk) begin
		if (!rstn) begin
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LLAS_RESP_OKAY;
		end else begin
			s_axi_awready <= !awHave_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !wHave_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_q <= 1'b1;
				awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wrGo) begin
				awHave_q <= 1'b0;
				wHave_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (awaddr_q == `LLAS_CTRL_ADDR || awaddr_q == `LLAS_LAMP_ADDR) begin
					s_axi_bresp <= `LLAS_RESP_OKAY;
				end else if (awaddr_q == `LLAS_STAT_ADDR) begin
					s_axi_bresp <= `LLAS_RESP_OKAY;
				end else begin
					s_axi_bresp <= `LLAS_RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read channel, one read at a time
	always @(posedge clk) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `LLAS_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `LLAS_RESP_OKAY;
				if (s_axi_araddr[7:2] == `LLAS_CTRL_IDX) begin
					s_axi_rdata <= {16'h0000, ctrl_q};
				end else if (s_axi_araddr[7:2] == `LLAS_LAMP_IDX) begin
					s_axi_rdata <= {16'h0000, lampMode_q, 14'h0000};
				end else if (s_axi_araddr[7:2] == `LLAS_STAT_IDX) begin
					s_axi_rdata <= {27'h0000000, statusLampOut, pinLevel, fiberLevel,
						actLevel, linkLevel};
				end else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `LLAS_RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// *** llas_lamp_strap_chk.sv ***
// port checks of the lamp pin and strap block
`timescale 1ns/1ps
module llas_chk (
	// clock, reset
	input wire clk,
	input wire rstn,
	// pin, status
	input wire statusLampIn,
	input wire statusLampOut,
	input wire statusLampOe,
	input wire statusLampPullup,
	input wire linkUp,
	input wire fiberModeSelect,
	input wire autonegEnable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_pin_in_reset: assert property ($rose(rstn) |-> !statusLampOe && statusLampPullup)
		else $error("pin driven in reset");
	a_pin_driven: assert property ($past(rstn) |-> statusLampOe && !statusLampPullup)
		else $error("pin not driven");
	a_strap_high: assert property ($rose(rstn) && statusLampIn && !fiberModeSelect
		|-> ##[1:4] autonegEnable) else $error("strap high lost");
	a_strap_low: assert property ($rose(rstn) && !statusLampIn
		|=> (!autonegEnable)[*4]) else $error("strap low lost");
	a_fiber_off: assert property ($rose(rstn) && fiberModeSelect
		|=> (!autonegEnable)[*4]) else $error("fiber left autoneg on");
	// no link: lamp off in every mode, 3 cycle input lag
	a_no_link: assert property ((statusLampOe && !linkUp)[*4] |-> statusLampOut)
		else $error("lamp lit without link");
endmodule
bind llas_lamp_strap llas_chk i_llas_chk (.clk, .rstn, .statusLampIn, .statusLampOut,
	.statusLampOe, .statusLampPullup, .linkUp, .fiberModeSelect, .autonegEnable);

// *** llas_lamp_strap_tb_top.sv ***
// self-checking bench of the lamp and strap block
`timescale 1ns/1ps
`include "llas_map.vh"
module llas_lamp_strap_tb_top;
	logic clk = 0, rstn = 0, statusLampIn, statusLampOut, statusLampOe, statusLampPullup, pv;
	logic linkUp = 0, activity = 0, fiberModeSelect = 0, autonegEnable, strapLevel = 1;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, wd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
	int failures = 0, n_tests = 0, md, tog;
	llas_lamp_strap #(.BLINK_CYC(4)) i_llas_lamp_strap (.*);
	llas_board i_llas_board (.statusLampOut, .statusLampOe, .strapLevel, .pinLevel(statusLampIn));
	initial forever #20 clk = ~clk;
	task automatic chk(input string nm, input logic [31:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1);
		br = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task automatic rst(input logic s, f);
		@(posedge clk);
		rstn <= 0;
		strapLevel <= s;
		fiberModeSelect <= f;
		repeat (5) @(posedge clk);
		rstn <= 1;
		repeat (5) @(posedge clk);
	endtask
	// steady value, or toggles seen over three blink periods
	task automatic lamp(input logic l, a);
		linkUp <= l;
		activity <= a;
		repeat (8) @(posedge clk);
		tog = 0;
		pv = statusLampOut;
		repeat (12) begin
			@(posedge clk);
			if (statusLampOut !== pv) tog++;
			pv = statusLampOut;
		end
		if (a) chk("blink", md == 0 && l, tog > 0);
		else chk("lamp", md < 2 ? !l : 1, statusLampOut);
	endtask
	task automatic stop_test;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		wd = $urandom(32'h6fd3c9f8);
		for (int k = 0; k < 4; k++) begin
			rst(k[0], k[1]);
			chk("autoneg", k == 1, autonegEnable);
			rdr(`LLAS_CTRL_ADDR);
			chk("ctrl", {31'h0, k == 1} << `LLAS_ANEN_BIT, rd);
			$display("strap %0d done", k);
		end
		wd = $urandom;
		wr(`LLAS_CTRL_ADDR, wd);
		chk("bresp", `LLAS_RESP_OKAY, br);
		rdr(`LLAS_CTRL_ADDR);
		chk("ctrl rw", wd & 32'hffff, rd);
		chk("autoneg sw", wd[12], autonegEnable);
		for (md = 0; md < 4; md++) begin
			wr(`LLAS_LAMP_ADDR, md << `LLAS_MODE_LO);
			rdr(`LLAS_LAMP_ADDR);
			chk("mode", md, rd[15:14]);
			for (int j = 0; j < 4; j++) lamp(j[0], j[1]);
			$display("mode %0d done", md);
		end
		rdr(8'h40);
		chk("unmapped", `LLAS_RESP_SLVERR, rr);
		chk("unmapped data", 32'h0, rd);
		wr(8'h40, wd);
		chk("unmapped wr", `LLAS_RESP_SLVERR, br);
		rdr(`LLAS_STAT_ADDR);
		// reserved mode: lamp off, driven pin follows it high
		chk("status", {27'h0, 2'b11, fiberModeSelect, activity, linkUp}, rd);
		$display("regs done");
		stop_test;
	end
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		stop_test;
	end
endmodule

// *** llas_map.vh ***
// register map, field positions, reset values and timing counts of the lamp and strap block
`ifndef LLAS_MAP_VH
`define LLAS_MAP_VH
`define LLAS_CTRL_IDX 6'h00
`define LLAS_LAMP_IDX 6'h1e
`define LLAS_STAT_IDX 6'h1f
`define LLAS_CTRL_ADDR {`LLAS_CTRL_IDX, 2'h0}
`define LLAS_LAMP_ADDR {`LLAS_LAMP_IDX, 2'h0}
`define LLAS_STAT_ADDR {`LLAS_STAT_IDX, 2'h0}
`define LLAS_ANEN_BIT 12
`define LLAS_MODE_HI 15
`define LLAS_MODE_LO 14
`define LLAS_STAT_LINK 0
`define LLAS_STAT_ACT 1
`define LLAS_STAT_FIBER 2
`define LLAS_STAT_STRAP 3
`define LLAS_CTRL_RST 16'h0000
`define LLAS_MODE_RST 2'h0
`define LLAS_MODE_LINKACT 2'h0
`define LLAS_MODE_LINK 2'h1
`define LLAS_BLINK_MS 50
`define LLAS_CLK_KHZ 25000
`define LLAS_BLINK_CYC (`LLAS_BLINK_MS * `LLAS_CLK_KHZ)
`define LLAS_RESP_OKAY 2'h0
`define LLAS_RESP_SLVERR 2'h2
`endif
